// ===== dv/cpu_model.sv
`timescale 1ns/10ps
module cpu_model import tivm_pkg::*; (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire vec_out_t   vector_in,
  input  wire logic       en_in,
  input  wire logic [3:0] dly_in,
  output logic            cpu_ack_out
);
  logic [3:0] wait_reg;
  logic [3:0] wait_next;
  logic       ack_reg;
  logic       ack_next;
  logic       hold_reg;
  // The shown vector lags an ack by two edges, so a hold cycle stops a second ack of the same vector.
  always_comb begin
    ack_next = 1'b0;
    wait_next = 4'h0;
    if (en_in && vector_in.valid && !ack_reg && !hold_reg) begin
      if (wait_reg >= dly_in) ack_next = 1'b1;
      else wait_next = wait_reg + 4'h1;
    end
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_reg <= 4'h0;
      ack_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      ack_reg <= ack_next;
      hold_reg <= ack_reg;
    end
  end
  assign cpu_ack_out = ack_reg;
endmodule

// ===== dv/testbench.sv
`timescale 1ns/10ps
module testbench import tivm_pkg::*; ;
  logic         clk;
  logic         resetn;
  logic [7:0]   addr;
  logic         rd;
  logic         wr;
  logic [31:0]  wdata;
  logic [31:0]  rdata;
  logic         waitreq;
  logic [7:0]   trap_req;
  logic [117:0] irq_req;
  logic         ack;
  logic         en;
  logic [3:0]   dly;
  vec_out_t     vec;
  logic         pc_load;
  logic [23:0]  pc_val;
  int           fail_count;
  int           num_checks;
  trap_vector_map #(.NUM_IRQ(118), .ALT_BASE(24'h000100)) uut (.ref_clk_in(clk), .resetn_in(resetn),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h3), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .trap_req_in(trap_req), .irq_req_in(irq_req), .cpu_ack_in(ack), .vector_out(vec),
    .pc_load_out(pc_load), .pc_value_out(pc_val));
  cpu_model cpu (.ref_clk_in(clk), .resetn_in(resetn), .vector_in(vec), .en_in(en), .dly_in(dly),
    .cpu_ack_out(ack));
  always #20 clk = ~clk;
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Wide enough for the reset snapshot of pc load, pc value and the whole vector.
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  // Waits are bounded so a dead handshake ends the run instead of hanging it.
  task automatic bus_wait();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (i > 20) begin
        fail_count++;
        report_and_stop();
      end
    end while (waitreq !== 1'b0);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0, d};
    wr <= 1'b1;
    bus_wait();
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    bus_wait();
    d = rdata[15:0];
    rd <= 1'b0;
  endtask
  task automatic wait_valid(input logic want);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
      if (i > 20) begin
        fail_count++;
        report_and_stop();
      end
    end while (vec.valid !== want);
  endtask
  task automatic pulse(input logic [7:0] t, input logic [117:0] q);
    @(posedge clk);
    trap_req <= t;
    irq_req <= q;
    @(posedge clk);
    trap_req <= 8'h0;
    irq_req <= '0;
  endtask
  task automatic t_traps();
    logic [15:0] r;
    logic [15:0] fl [8];
    fl = '{16'h0002, 16'h0008, 16'h0000, 16'h0004, 16'h0010, 16'h0000, 16'h0000, 16'h0000};
    en <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      dly <= n[3:0];
      pulse(8'h1 << n, '0);
      if (n == 5 || n == 7) begin
        repeat (3) @(negedge clk);
        chk("rsvd_valid", 36'h0, {35'h0, vec.valid});
      end else begin
        wait_valid(1'b1);
        chk("trap_vec", {1'b1, 7'(n), 24'h4 + 24'(2 * n), 4'(15 - n)}, vec);
        wait_valid(1'b0);
        bus_rd(8'h02, r);
        chk("taken", {4'(15 - n), 7'(n)}, r[10:0]);
      end
      bus_rd(8'h00, r);
      chk("trap_flags", fl[n], r);
      bus_wr(8'h00, 16'h0);
    end
  endtask
  task automatic t_irq(input int n);
    logic [15:0] r;
    bus_wr(8'h18 + 8'(n / 16), 16'h1 << (n % 16));
    bus_wr(8'h20 + 8'(n / 4), 16'h3 << (4 * (n % 4)));
    pulse(8'h0, 118'h1 << n);
    wait_valid(1'b1);
    chk("irq_vec", {1'b1, 7'(n + 8), 24'h14 + 24'(2 * n), 4'h3}, vec);
    bus_rd(8'h10 + 8'(n / 16), r);
    chk("irq_flag", 16'h1 << (n % 16), r);
    bus_wr(8'h10 + 8'(n / 16), 16'h0);
    wait_valid(1'b0);
    bus_wr(8'h18 + 8'(n / 16), 16'h0);
    bus_wr(8'h20 + 8'(n / 4), 16'h0);
  endtask
  task automatic t_order();
    en <= 1'b0;
    dly <= 4'h0;
    bus_wr(8'h18, 16'h0006);
    bus_wr(8'h20, 16'h0550);
    pulse(8'h0, 118'h6);
    wait_valid(1'b1);
    chk("tie", {1'b1, 7'd9, 24'h16, 4'h5}, vec);
    bus_wr(8'h20, 16'h0650);
    repeat (2) @(negedge clk);
    chk("prio", {1'b1, 7'd10, 24'h18, 4'h6}, vec);
    bus_wr(8'h01, 16'h0100);
    repeat (2) @(negedge clk);
    chk("alt_irq", {1'b1, 7'd10, 24'h114, 4'h6}, vec);
    pulse(8'h04, '0);
    repeat (2) @(negedge clk);
    chk("trap_first", {1'b1, 7'd2, 24'h104, 4'hd}, vec);
    en <= 1'b1;
    repeat (6) @(negedge clk);
    chk("user_back", {1'b1, 7'd10, 24'h114, 4'h6}, vec);
    bus_wr(8'h01, 16'h0);
    bus_wr(8'h10, 16'h0);
    bus_wr(8'h18, 16'h0);
    bus_wr(8'h20, 16'h0);
    wait_valid(1'b0);
  endtask
  task automatic t_unimpl();
    logic [15:0] r;
    bus_wr(8'h19, 16'h0020);
    bus_rd(8'h19, r);
    chk("unimpl_en", 16'h0, r);
    pulse(8'h0, 118'h1 << 21);
    bus_rd(8'h11, r);
    chk("unimpl_flag", 16'h0, r);
    bus_wr(8'h40, 16'h1234);
    bus_rd(8'h40, r);
    chk("unmapped", 16'h0, r);
  endtask
  task automatic t_rerun();
    logic [15:0] r;
    pulse(8'h0, 118'h1);
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    chk("rst_state", {1'b1, 24'h0, 36'h0}, {pc_load, pc_val, vec});
    @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("pc_load_one", 1'b1, pc_load);
    @(negedge clk);
    chk("pc_load_end", {1'b0, 1'b0}, {pc_load, vec.valid});
    bus_rd(8'h10, r);
    chk("flag_rst", 16'h0, r);
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    addr = 8'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    trap_req = 8'h0;
    irq_req = '0;
    en = 1'b0;
    dly = 4'h0;
    fail_count = 0;
    num_checks = 0;
    @(negedge clk);
    chk("rst_state", {1'b1, 24'h0, 36'h0}, {pc_load, pc_val, vec});
    @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("pc_load_one", 1'b1, pc_load);
    t_traps();
    t_irq(0);
    t_irq(16);
    t_irq(20);
    t_irq(29);
    t_irq(53);
    t_irq(54);
    t_irq(117);
    t_order();
    t_unimpl();
    t_rerun();
    report_and_stop();
  end
endmodule

// ===== include/tivm_params.svh
// Functional notes
// - Reset bypasses arbitration and vectoring entirely.
// - Reset restores registers and zeroes program counter.
// - First fetch after reset comes from 000000h.
// - Oscillator failure: vector 0, offset 000004h, level 15.
// - Address error: vector 1, offset 000006h, level 14.
// - Hardware error: vector 2, offset 000008h, level 13.
// - Stack error: vector 3, offset 00000Ah, level 12.
// - Math error: vector 4, offset 00000Ch, level 11.
// - Vector 6 software error; vectors 5, 7 reserved.
// - Request n uses vector n+8, offset 000014h+2n.
// - Flag, enable at register n/16, bit n%16.
// - Priority field: register n/4, bit 4*(n%4).
// - Top vector 125, request 117, offset 0000FEh.
// - Extra pin requests 20, 29, 53, 54 served.
// - Equal priority: lower vector number wins.
// - Alternate select fetches every vector from alternate table.
// - Flags set by source, cleared by software write.
// - Three-bit field selects one of eight levels.
`ifndef TIVM_PARAMS_SVH
`define TIVM_PARAMS_SVH

`define RESET_ADDR       24'h000000
`define TABLE_BASE       24'h000004
`define ALT_TABLE_BASE   24'h000100
`define IRQ_VEC_OFFSET   7'h08
`define TRAP_TOP_LEVEL   4'hf
`define TRAP_IMPL_MASK   8'h5f
`define IRQ_IMPL_MASK    128'h003fe47f_fffe63cf_ffefffff_ffdfffff
`define IRQ_SLOTS        128
`define NUM_IRQ_DEF      118

`define REG_TRAP_CTRL    8'h00
`define REG_CTRL_TWO     8'h01
`define REG_TAKEN        8'h02
`define REG_FLAG_BASE    8'h10
`define REG_EN_BASE      8'h18
`define REG_PRIO_BASE    8'h20
`define FLAG_REGS        8'h08
`define PRIO_REGS        8'h1e

`define BIT_OSC_FAIL     1
`define BIT_STK_ERR      2
`define BIT_ADDR_ERR     3
`define BIT_MATH_ERR     4
`define BIT_ALT_SEL      8
`define PRIO_STRIDE      4

`endif

// ===== include/tivm_pkg.sv
package tivm_pkg;

  typedef logic [2:0] prio_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  num;
    logic [23:0] addr;
    logic [3:0]  level;
  } vec_out_t;

  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_RUN  = 1'b1
  } ctl_state_t;

endpackage

// ===== rtl/irq_pick.sv
`timescale 1ns/10ps
module irq_pick import tivm_pkg::*; #(
  parameter int N = 128
) (
  input  wire logic             ref_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [N-1:0]     elig_in,
  input  wire logic [3*N-1:0]   levels_in,
  output logic                  win_valid_out,
  output logic [6:0]            win_idx_out,
  output prio_t                 win_level_out
);

  generate
    if (N < 1 || N > 128) begin : g_bad_n
      $error("irq_pick supports 1 to 128 sources");
    end
  endgenerate

  logic better_lower;

  // Scanning downward with >= lets a lower index take over an equal level.
  always_comb begin
    win_valid_out = 1'b0;
    win_idx_out   = 7'h00;
    win_level_out = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig_in[i] && (!win_valid_out || levels_in[3*i +: 3] >= win_level_out)) begin
        win_valid_out = 1'b1;
        win_idx_out   = 7'(i);
        win_level_out = levels_in[3*i +: 3];
      end
    end
  end

  always_comb begin
    better_lower = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (elig_in[i] && 7'(i) < win_idx_out && levels_in[3*i +: 3] >= win_level_out) begin
        better_lower = 1'b1;
      end
    end
  end

  tie_break_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    win_valid_out |-> !better_lower && elig_in[win_idx_out])
    else $error("winner is not the lowest index at the top level");

endmodule

// ===== rtl/trap_vector_map.sv
`timescale 1ns/10ps
`include "tivm_params.svh"
module trap_vector_map import tivm_pkg::*; #(
  parameter int          NUM_IRQ  = `NUM_IRQ_DEF,
  parameter logic [23:0] ALT_BASE = `ALT_TABLE_BASE
) (
  input  wire logic                ref_clk_in,
  input  wire logic                resetn_in,
  input  wire logic [7:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic [31:0]              avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  wire logic [7:0]          trap_req_in,
  input  wire logic [NUM_IRQ-1:0]  irq_req_in,
  input  wire logic                cpu_ack_in,
  output vec_out_t                 vector_out,
  output logic                     pc_load_out,
  output logic [23:0]              pc_value_out
);

  localparam int S = `IRQ_SLOTS;
  localparam logic [S-1:0] IMPL = `IRQ_IMPL_MASK & ~({S{1'b1}} << NUM_IRQ);

  generate
    if (NUM_IRQ < 1 || NUM_IRQ > S) begin : g_bad_irq
      $error("NUM_IRQ must lie between 1 and 128");
    end
    if (ALT_BASE[0] != 1'b0) begin : g_bad_base
      $error("ALT_BASE must be even");
    end
  endgenerate

  logic               ack_reg, ack_next;
  logic [15:0]        rdata_reg, rdata_next;
  logic [15:0]        trap_ctrl_reg, trap_ctrl_next;
  logic               alt_sel_reg, alt_sel_next;
  logic [7:0]         trap_pend_reg, trap_pend_next;
  logic [S-1:0]       flag_reg, flag_next;
  logic [S-1:0]       en_reg, en_next;
  logic [S-1:0][2:0]  prio_reg, prio_next;
  ctl_state_t         state_reg, state_next;
  vec_out_t           vec_reg, vec_next;
  logic [10:0]        taken_reg, taken_next;

  logic               wr_en;
  logic [15:0]        wmask;
  logic [15:0]        wdata;
  logic [7:0]         off;
  logic [15:0]        rd_val;
  logic [S-1:0]       irq_ext;
  logic [S-1:0]       elig;
  logic               win_valid;
  logic [6:0]         win_idx;
  prio_t              win_level;
  logic [2:0]         trap_num;
  logic [23:0]        base_sel;

  // One wait state per access keeps read data on a flop at the answer edge.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
  assign avs_readdata_out    = {16'h0000, rdata_reg};
  assign wr_en   = avs_write_in & ack_reg;
  assign wmask   = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wdata   = avs_writedata_in[15:0];
  assign irq_ext = S'(irq_req_in);

  // Bus group.
  always_comb begin
    ack_next   = (avs_read_in | avs_write_in) & ~ack_reg;
    rdata_next = rdata_reg;
    rd_val     = 16'h0000;
    off        = 8'h00;
    if (avs_address_in == `REG_TRAP_CTRL) begin
      rd_val = trap_ctrl_reg;
    end else if (avs_address_in == `REG_CTRL_TWO) begin
      rd_val[`BIT_ALT_SEL] = alt_sel_reg;
    end else if (avs_address_in == `REG_TAKEN) begin
      rd_val = {5'h00, taken_reg};
    end else if (avs_address_in >= `REG_FLAG_BASE && avs_address_in < `REG_FLAG_BASE + `FLAG_REGS) begin
      off    = avs_address_in - `REG_FLAG_BASE;
      rd_val = flag_reg[16*off[2:0] +: 16];
    end else if (avs_address_in >= `REG_EN_BASE && avs_address_in < `REG_EN_BASE + `FLAG_REGS) begin
      off    = avs_address_in - `REG_EN_BASE;
      rd_val = en_reg[16*off[2:0] +: 16];
    end else if (avs_address_in >= `REG_PRIO_BASE && avs_address_in < `REG_PRIO_BASE + `PRIO_REGS) begin
      off = avs_address_in - `REG_PRIO_BASE;
      for (int f = 0; f < 4; f++) begin
        rd_val[`PRIO_STRIDE*f +: 3] = prio_reg[{off[4:0], 2'(f)}];
      end
    end
    if (avs_read_in && !ack_reg) begin
      rdata_next = rd_val;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register group: software writes first, hardware sets afterwards so a set wins.
  always_comb begin
    trap_ctrl_next = trap_ctrl_reg;
    alt_sel_next   = alt_sel_reg;
    flag_next      = flag_reg;
    en_next        = en_reg;
    prio_next      = prio_reg;
    trap_pend_next = trap_pend_reg;
    if (wr_en) begin
      if (avs_address_in == `REG_TRAP_CTRL) begin
        trap_ctrl_next = (trap_ctrl_reg & ~wmask) | (wdata & wmask);
      end else if (avs_address_in == `REG_CTRL_TWO) begin
        if (avs_byteenable_in[1]) begin
          alt_sel_next = wdata[`BIT_ALT_SEL];
        end
      end else if (avs_address_in >= `REG_FLAG_BASE && avs_address_in < `REG_FLAG_BASE + `FLAG_REGS) begin
        flag_next[16*off[2:0] +: 16] = (flag_reg[16*off[2:0] +: 16] & ~wmask) | (wdata & wmask);
      end else if (avs_address_in >= `REG_EN_BASE && avs_address_in < `REG_EN_BASE + `FLAG_REGS) begin
        en_next[16*off[2:0] +: 16] = (en_reg[16*off[2:0] +: 16] & ~wmask) | (wdata & wmask);
      end else if (avs_address_in >= `REG_PRIO_BASE && avs_address_in < `REG_PRIO_BASE + `PRIO_REGS) begin
        for (int f = 0; f < 4; f++) begin
          if (avs_byteenable_in[f/2]) begin
            prio_next[{off[4:0], 2'(f)}] = wdata[`PRIO_STRIDE*f +: 3];
          end
        end
      end
    end
    if (cpu_ack_in && vec_reg.valid && vec_reg.num < `IRQ_VEC_OFFSET) begin
      trap_pend_next[vec_reg.num[2:0]] = 1'b0;
    end
    trap_pend_next = trap_pend_next | (trap_req_in & `TRAP_IMPL_MASK);
    if (trap_req_in[0]) begin
      trap_ctrl_next[`BIT_OSC_FAIL] = 1'b1;
    end
    if (trap_req_in[1]) begin
      trap_ctrl_next[`BIT_ADDR_ERR] = 1'b1;
    end
    if (trap_req_in[3]) begin
      trap_ctrl_next[`BIT_STK_ERR] = 1'b1;
    end
    if (trap_req_in[4]) begin
      trap_ctrl_next[`BIT_MATH_ERR] = 1'b1;
    end
    trap_ctrl_next = trap_ctrl_next & 16'h001e;
    flag_next = (flag_next | irq_ext) & IMPL;
    en_next   = en_next & IMPL;
    for (int i = 0; i < S; i++) begin
      if (!IMPL[i]) begin
        prio_next[i] = 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trap_ctrl_reg <= 16'h0000;
      alt_sel_reg   <= 1'b0;
      trap_pend_reg <= 8'h00;
      flag_reg      <= '0;
      en_reg        <= '0;
      prio_reg      <= '0;
    end else begin
      trap_ctrl_reg <= trap_ctrl_next;
      alt_sel_reg   <= alt_sel_next;
      trap_pend_reg <= trap_pend_next;
      flag_reg      <= flag_next;
      en_reg        <= en_next;
      prio_reg      <= prio_next;
    end
  end

  // Level zero keeps a source out of arbitration, leaving seven usable user levels.
  always_comb begin
    for (int i = 0; i < S; i++) begin
      elig[i] = flag_reg[i] & en_reg[i] & IMPL[i] & (prio_reg[i] != 3'h0);
    end
  end

  irq_pick #(
    .N (S)
  ) u_pick (
    .ref_clk_in    (ref_clk_in),
    .resetn_in     (resetn_in),
    .elig_in       (elig),
    .levels_in     (prio_reg),
    .win_valid_out (win_valid),
    .win_idx_out   (win_idx),
    .win_level_out (win_level)
  );

  // Vector group.
  always_comb begin
    state_next = ST_RUN;
    taken_next = taken_reg;
    vec_next   = '0;
    trap_num   = 3'h0;
    base_sel   = alt_sel_reg ? ALT_BASE : `TABLE_BASE;
    for (int i = 7; i >= 0; i--) begin
      if (trap_pend_reg[i]) begin
        trap_num = 3'(i);
      end
    end
    case (state_reg)
      ST_BOOT: begin
        vec_next.valid = 1'b0;
      end
      ST_RUN: begin
        if (|trap_pend_reg) begin
          vec_next.valid = 1'b1;
          vec_next.num   = {4'h0, trap_num};
          vec_next.level = `TRAP_TOP_LEVEL - {1'b0, trap_num};
        end else if (win_valid) begin
          vec_next.valid = 1'b1;
          vec_next.num   = win_idx + `IRQ_VEC_OFFSET;
          vec_next.level = {1'b0, win_level};
        end
      end
      default: begin
        vec_next.valid = 1'b0;
      end
    endcase
    if (vec_next.valid) begin
      vec_next.addr = base_sel + {16'h0000, vec_next.num, 1'b0};
    end
    if (cpu_ack_in && vec_reg.valid) begin
      taken_next = {vec_reg.level, vec_reg.num};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_BOOT;
      vec_reg   <= '0;
      taken_reg <= 11'h000;
    end else begin
      state_reg <= state_next;
      vec_reg   <= vec_next;
      taken_reg <= taken_next;
    end
  end

  assign vector_out   = vec_reg;
  assign pc_load_out  = (state_reg == ST_BOOT);
  assign pc_value_out = `RESET_ADDR;

  localparam int BUS_MAX = 1;

  reset_no_vector_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    pc_load_out |=> !vector_out.valid && !pc_load_out)
    else $error("reset was vectored or held the pc load");

  reset_pc_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    pc_load_out |-> pc_value_out == `RESET_ADDR && !vector_out.valid)
    else $error("pc load did not carry address zero");

  trap_map_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    vector_out.valid && vector_out.num < `IRQ_VEC_OFFSET |->
      vector_out.level == `TRAP_TOP_LEVEL - vector_out.num[3:0] &&
      vector_out.addr == ($past(alt_sel_reg) ? ALT_BASE : `TABLE_BASE) + {vector_out.num, 1'b0})
    else $error("trap vector level or address wrong");

  irq_map_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    vector_out.valid && vector_out.num >= `IRQ_VEC_OFFSET |->
      vector_out.level[3] == 1'b0 &&
      vector_out.addr == ($past(alt_sel_reg) ? ALT_BASE : `TABLE_BASE) + {vector_out.num, 1'b0})
    else $error("request vector level or address wrong");

  trap_first_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (state_reg == ST_RUN && (trap_pend_reg & ~trap_req_in) != 8'h00) |=>
      vector_out.valid && vector_out.num < `IRQ_VEC_OFFSET)
    else $error("pending trap not presented ahead of requests");

  flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (irq_ext & IMPL) != '0 |=> (flag_reg & $past(irq_ext & IMPL)) == $past(irq_ext & IMPL))
    else $error("request flag lost its set");

  unimpl_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (flag_reg & ~IMPL) == '0 && (en_reg & ~IMPL) == '0)
    else $error("unimplemented request bit is set");

  osc_flag_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    trap_req_in[0] |=> trap_ctrl_reg[`BIT_OSC_FAIL] && trap_pend_reg[0])
    else $error("oscillator failure not recorded");

  bus_answer_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (avs_read_in || avs_write_in) |-> ##[0:BUS_MAX] !avs_waitrequest_out)
    else $error("bus answer too late");

endmodule
